/* File: rtl/cecd_exec.sv */
// Purpose: executes call-via-accumulator, clears, watchdog kick, complement, decrements
// Assumes: op_valid pulses one cycle per issued instruction while op_ready is high
// Notes: a two-cycle instruction holds op_ready low for its second cycle
`timescale 1ns/10ps
module cecd_exec import cecd_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire cecd_op_t op,
  input wire logic [CECD_FW-1:0] file_addr,
  input wire logic dest_bit,
  input wire logic [CECD_DW-1:0] file_rdata,
  input wire logic [CECD_LW-1:0] program_counter_upper_latch,
  input wire logic fetch_advance,
  output logic op_ready,
  output logic [CECD_DW-1:0] accumulator,
  output logic [CECD_PCW-1:0] program_counter,
  output logic [CECD_PCW-1:0] stack_top,
  output logic stack_push,
  output logic file_we,
  output logic [CECD_FW-1:0] file_waddr,
  output logic [CECD_DW-1:0] file_wdata,
  output logic result_null_flag,
  output logic watchdog_expiry_flag,
  output logic sleep_entry_flag,
  output logic watchdog_clear,
  output logic discard_next
);
  // ==========================================================
  // state
  typedef enum logic [1:0] {CECD_ST_RUN, CECD_ST_CALL2, CECD_ST_NOP2} cecd_state_t;
  cecd_state_t st_q, st_d; // execution phase
  logic [CECD_DW-1:0] acc_q, acc_d; // accumulator
  logic [CECD_PCW-1:0] pc_q, pc_d; // program counter
  logic [CECD_PCW-1:0] tos_q, tos_d; // stack top
  logic push_q, push_d; // stack push strobe
  logic fwe_q, fwe_d; // file write strobe
  logic [CECD_FW-1:0] fwa_q, fwa_d; // file write address
  logic [CECD_DW-1:0] fwd_q, fwd_d; // file write data
  logic z_q, z_d; // zero flag
  logic to_q, to_d; // expiry flag, active low
  logic pd_q, pd_d; // sleep flag, active low
  logic wdc_q, wdc_d; // watchdog clear strobe
  logic disc_q, disc_d; // discard strobe
  logic [CECD_DW-1:0] alu_res; // alu result
  logic alu_zero; // alu zero detect
  logic take; // instruction accepted

  // ==========================================================
  // result unit
  cecd_alu u_alu (
    .op(op),
    .operand(file_rdata),
    .result(alu_res),
    .result_zero(alu_zero)
  );

  assign take = op_valid && (st_q == CECD_ST_RUN);
  assign op_ready = (st_q == CECD_ST_RUN); // low in second cycle

  // ==========================================================
  // next-state logic
  always_comb begin
    st_d = CECD_ST_RUN;
    acc_d = acc_q;
    pc_d = fetch_advance ? pc_q + CECD_PC_INC : pc_q;
    tos_d = tos_q;
    push_d = 1'b0;
    fwe_d = 1'b0;
    fwa_d = fwa_q;
    fwd_d = fwd_q;
    z_d = z_q;
    to_d = to_q;
    pd_d = pd_q;
    wdc_d = 1'b0;
    disc_d = 1'b0;
    if (take) begin
      case (op)
        CECD_OP_CALL_ACC: begin
          tos_d = pc_q + CECD_PC_INC;
          push_d = 1'b1;
          pc_d = {program_counter_upper_latch, acc_q};
          st_d = CECD_ST_CALL2;
        end
        CECD_OP_CLR_FILE: begin
          fwe_d = 1'b1;
          fwa_d = file_addr;
          fwd_d = CECD_ZERO8;
          z_d = 1'b1;
        end
        CECD_OP_CLR_ACC: begin
          acc_d = CECD_ZERO8;
          z_d = 1'b1;
        end
        CECD_OP_WDT_KICK: begin
          wdc_d = 1'b1;
          to_d = 1'b1;
          pd_d = 1'b1;
        end
        CECD_OP_COMP, CECD_OP_DEC, CECD_OP_DEC_SKIP: begin
          if (dest_bit) begin
            fwe_d = 1'b1;
            fwa_d = file_addr;
            fwd_d = alu_res;
          end else begin
            acc_d = alu_res;
          end
          if (op != CECD_OP_DEC_SKIP) begin
            z_d = alu_zero;
          end else if (alu_zero) begin
            disc_d = 1'b1;
            st_d = CECD_ST_NOP2;
          end
        end
        default: begin
          st_d = CECD_ST_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= CECD_ST_RUN;
      acc_q <= CECD_ZERO8;
      pc_q <= CECD_PC_RST;
      tos_q <= CECD_PC_RST;
      push_q <= 1'b0;
      fwe_q <= 1'b0;
      fwa_q <= '0;
      fwd_q <= CECD_ZERO8;
      z_q <= 1'b0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
      wdc_q <= 1'b0;
      disc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      acc_q <= acc_d;
      pc_q <= pc_d;
      tos_q <= tos_d;
      push_q <= push_d;
      fwe_q <= fwe_d;
      fwa_q <= fwa_d;
      fwd_q <= fwd_d;
      z_q <= z_d;
      to_q <= to_d;
      pd_q <= pd_d;
      wdc_q <= wdc_d;
      disc_q <= disc_d;
    end
  end

  assign accumulator = acc_q;
  assign program_counter = pc_q;
  assign stack_top = tos_q;
  assign stack_push = push_q;
  assign file_we = fwe_q;
  assign file_waddr = fwa_q;
  assign file_wdata = fwd_q;
  assign result_null_flag = z_q;
  assign watchdog_expiry_flag = to_q;
  assign sleep_entry_flag = pd_q;
  assign watchdog_clear = wdc_q;
  assign discard_next = disc_q;

  // ==========================================================
  // checks
  sequence s_call_issue;
    op_valid && op_ready && op == CECD_OP_CALL_ACC;
  endsequence

  AST_CALL_PUSH: assert property (@(posedge clk) disable iff (sys_rst)
    s_call_issue |=> stack_push && stack_top == $past(pc_q) + CECD_PC_INC)
    else $error("call did not push next address");
  AST_CALL_PC: assert property (@(posedge clk) disable iff (sys_rst)
    s_call_issue |=> program_counter == {$past(program_counter_upper_latch), $past(acc_q)})
    else $error("call target wrong");
  AST_CALL_TWO: assert property (@(posedge clk) disable iff (sys_rst)
    s_call_issue |=> !op_ready ##1 op_ready && $stable(result_null_flag))
    else $error("call not two cycles or flag moved");
  AST_CLEAR_FILE_REGISTER: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_ready && op == CECD_OP_CLR_FILE |=>
    file_we && file_wdata == CECD_ZERO8 && result_null_flag)
    else $error("clear file wrong");
  AST_CLEAR_ACCUMULATOR: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_ready && op == CECD_OP_CLR_ACC |=>
    accumulator == CECD_ZERO8 && result_null_flag)
    else $error("clear accumulator wrong");
  AST_KICK: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_ready && op == CECD_OP_WDT_KICK |=>
    watchdog_clear && watchdog_expiry_flag && sleep_entry_flag)
    else $error("watchdog kick wrong");
  AST_COMP_ACC: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_ready && op == CECD_OP_COMP && !dest_bit |=>
    accumulator == ~$past(file_rdata) && !file_we)
    else $error("complement to accumulator wrong");
  AST_DSZ_SKIP: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_ready && op == CECD_OP_DEC_SKIP && file_rdata == CECD_ONE8 |=>
    discard_next && !op_ready ##1 op_ready)
    else $error("skip not taken");
  AST_DSZ_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_ready && op == CECD_OP_DEC_SKIP |=> $stable(result_null_flag))
    else $error("decrement-skip moved zero flag");
  // both decrements write the decremented value back when the destination bit is set
  AST_DEC_REG: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_ready && (op == CECD_OP_DEC || op == CECD_OP_DEC_SKIP) && dest_bit |=>
    file_we && file_waddr == $past(file_addr) && file_wdata == $past(file_rdata) - CECD_ONE8)
    else $error("decrement to register wrong");
  // plain decrement follows the result with the zero flag
  AST_DEC_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_ready && op == CECD_OP_DEC |=>
    result_null_flag == ($past(file_rdata) == CECD_ONE8))
    else $error("decrement zero flag wrong");
  // a nonzero decrement-skip result runs on without a stall or discard
  AST_DSZ_RUN: assert property (@(posedge clk) disable iff (sys_rst)
    op_valid && op_ready && op == CECD_OP_DEC_SKIP && file_rdata != CECD_ONE8 |=>
    !discard_next && op_ready)
    else $error("skip taken on nonzero result");
endmodule // cecd_exec

/* File: rtl/cecd_pkg.sv */
// Purpose: shared constants for the call/clear/decrement execution block
// Assumes: 8-bit data path, 15-bit program counter, 7-bit file address
// Notes: operation codes are local to this block
package cecd_pkg;
  // ==========================================================
  // widths
  localparam int CECD_DW = 8;
  localparam int CECD_PCW = 15;
  localparam int CECD_FW = 7;
  localparam int CECD_LW = 7;
  // ==========================================================
  // field positions of the program counter
  localparam int CECD_PC_LO_MSB = 7;
  localparam int CECD_PC_HI_LSB = 8;
  // ==========================================================
  // reset values and constants
  localparam logic [7:0] CECD_ZERO8 = 8'h00;
  localparam logic [7:0] CECD_ONE8 = 8'h01;
  localparam logic [14:0] CECD_PC_RST = 15'h0000;
  localparam logic [14:0] CECD_PC_INC = 15'h0001;
  // ==========================================================
  // cycle counts
  localparam int CECD_CYC_ONE = 1;
  localparam int CECD_CYC_TWO = 2;
  // ==========================================================
  // operations handled here
  typedef enum logic [2:0] {
    CECD_OP_NONE,
    CECD_OP_CALL_ACC,
    CECD_OP_CLR_FILE,
    CECD_OP_CLR_ACC,
    CECD_OP_WDT_KICK,
    CECD_OP_COMP,
    CECD_OP_DEC,
    CECD_OP_DEC_SKIP
  } cecd_op_t;
endpackage

/* File: rtl/cecd_alu.sv */
// Purpose: combinational result unit for complement, decrement, clear
// Assumes: operands valid in the cycle the operation is issued
// Notes: zero detect follows the result
`timescale 1ns/10ps
module cecd_alu import cecd_pkg::*; (
  input wire cecd_op_t op,
  input wire logic [CECD_DW-1:0] operand,
  output logic [CECD_DW-1:0] result,
  output logic result_zero
);
  // ==========================================================
  // result selection
  always_comb begin
    case (op)
      CECD_OP_COMP: result = ~operand;
      CECD_OP_DEC, CECD_OP_DEC_SKIP: result = operand - CECD_ONE8;
      default: result = CECD_ZERO8;
    endcase
    result_zero = (result == CECD_ZERO8);
  end
endmodule // cecd_alu

/* File: testbench/cpu_exec_call_clear_dec_ops_tb_top.sv */
// Purpose: self-checking bench for the call/clear/decrement execution block
// Assumes: one clock, synchronous active-high reset, ports driven directly
// Notes: each scenario after the reset check issues operations and checks outputs one edge later
`timescale 1ns/10ps
module cpu_exec_call_clear_dec_ops_tb_top import cecd_pkg::*;;
  // ==========================================================
  // stimulus and observed signals
  logic clk, sys_rst, op_valid, dest_bit, fetch_advance; // driven inputs
  cecd_op_t op; // operation under issue
  logic [6:0] file_addr, upper_latch; // register select and pc upper source
  logic [7:0] file_rdata; // contents of the selected register
  logic op_ready, stack_push, file_we, result_null_flag; // outputs
  logic watchdog_expiry_flag, sleep_entry_flag, watchdog_clear, discard_next;
  logic [7:0] accumulator, file_wdata;
  logic [6:0] file_waddr;
  logic [14:0] program_counter, stack_top;
  int err_total, check_count; // mismatch and comparison counters
  // ==========================================================
  // design under test
  cecd_exec u_cecd_exec (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op(op),
    .file_addr(file_addr), .dest_bit(dest_bit), .file_rdata(file_rdata),
    .program_counter_upper_latch(upper_latch), .fetch_advance(fetch_advance),
    .op_ready(op_ready), .accumulator(accumulator), .program_counter(program_counter),
    .stack_top(stack_top), .stack_push(stack_push), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .result_null_flag(result_null_flag),
    .watchdog_expiry_flag(watchdog_expiry_flag), .sleep_entry_flag(sleep_entry_flag),
    .watchdog_clear(watchdog_clear), .discard_next(discard_next));
  // ==========================================================
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // verdict, compares and issue helper
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // single-bit result compare
  task chk_bit(input logic g, input logic e, input string m);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // multi-bit value compare, callers pad narrower values to the pc width
  task chk_val(input logic [14:0] g, input logic [14:0] e, input string m);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // one-cycle issue strobe; returns just after the taking edge
  task iss(input cecd_op_t o, input logic [6:0] a, input logic d, input logic [7:0] r);
    @(posedge clk);
    op_valid <= 1'b1;
    op <= o;
    file_addr <= a;
    dest_bit <= d;
    file_rdata <= r;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    chk_val({7'h00, accumulator}, 15'h0000, "acc reset");
    chk_val(program_counter, 15'h0000, "pc reset");
    chk_bit(result_null_flag, 1'b0, "zero flag reset");
    chk_bit(watchdog_expiry_flag & sleep_entry_flag, 1'b1, "status reset");
    chk_bit(op_ready, 1'b1, "ready reset");
    $display("test reset done");
  endtask
  task t_comp_clr;
    iss(CECD_OP_COMP, 7'h12, 1'b0, 8'h5a);
    chk_val({7'h00, accumulator}, 15'h00a5, "comp to acc");
    chk_bit(file_we, 1'b0, "comp acc no write");
    chk_bit(result_null_flag, 1'b0, "comp flag clear");
    iss(CECD_OP_COMP, 7'h7f, 1'b1, 8'hff);
    chk_bit(file_we, 1'b1, "comp reg write");
    chk_val({file_waddr, file_wdata}, 15'h7f00, "comp to reg");
    chk_bit(result_null_flag, 1'b1, "comp flag set");
    iss(CECD_OP_COMP, 7'h00, 1'b0, 8'h00);
    iss(CECD_OP_CLR_FILE, 7'h7f, 1'b1, 8'h33);
    chk_bit(file_we, 1'b1, "clear reg write");
    chk_val({file_waddr, file_wdata}, 15'h7f00, "clear reg");
    chk_bit(result_null_flag & op_ready, 1'b1, "clear reg flag");
    iss(CECD_OP_COMP, 7'h00, 1'b0, 8'h00);
    iss(CECD_OP_CLR_ACC, 7'h00, 1'b0, 8'h44);
    chk_val({7'h00, accumulator}, 15'h0000, "clear acc");
    chk_bit(result_null_flag, 1'b1, "clear acc flag");
    $display("test complement and clear done");
  endtask
  task t_dec_wdt;
    iss(CECD_OP_DEC, 7'h05, 1'b1, 8'h01);
    chk_bit(file_we, 1'b1, "dec reg write");
    chk_val({file_waddr, file_wdata}, 15'h0500, "dec to reg");
    chk_bit(result_null_flag, 1'b1, "dec flag set");
    iss(CECD_OP_DEC, 7'h05, 1'b0, 8'h00);
    chk_val({6'h00, file_we, accumulator}, 15'h00ff, "dec to acc");
    chk_bit(result_null_flag, 1'b0, "dec flag clear");
    iss(CECD_OP_WDT_KICK, 7'h00, 1'b0, 8'h00);
    chk_bit(watchdog_clear & op_ready, 1'b1, "kick clear");
    chk_bit(watchdog_expiry_flag & sleep_entry_flag, 1'b1, "kick status");
    chk_bit(result_null_flag, 1'b0, "kick keeps zero flag");
    $display("test decrement and kick done");
  endtask
  task t_skip_call;
    iss(CECD_OP_DEC_SKIP, 7'h09, 1'b1, 8'h01);
    chk_bit(file_we, 1'b1, "skip reg write");
    chk_val({file_waddr, file_wdata}, 15'h0900, "skip to reg");
    chk_bit(discard_next & ~op_ready, 1'b1, "skip taken");
    chk_bit(result_null_flag, 1'b0, "skip keeps flag");
    iss(CECD_OP_DEC_SKIP, 7'h09, 1'b0, 8'h05);
    chk_val({7'h00, accumulator}, 15'h0004, "skip to acc");
    chk_bit(discard_next | ~op_ready, 1'b0, "no skip");
    @(posedge clk);
    fetch_advance <= 1'b1;
    repeat (3) @(posedge clk);
    fetch_advance <= 1'b0;
    iss(CECD_OP_CALL_ACC, 7'h00, 1'b0, 8'h00);
    chk_bit(stack_push, 1'b1, "call push");
    chk_val(stack_top, 15'h0004, "call return address");
    chk_val(program_counter, 15'h3504, "call target");
    chk_bit(op_ready | result_null_flag, 1'b0, "call second cycle");
    @(posedge clk);
    #1;
    chk_bit(op_ready, 1'b1, "call done");
    $display("test skip and call done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {sys_rst, op_valid, dest_bit, fetch_advance} = 4'h8;
    op = CECD_OP_NONE;
    file_addr = 7'h00;
    upper_latch = 7'h35;
    file_rdata = 8'h00;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_comp_clr();
    t_dec_wdt();
    t_skip_call();
    end_sim();
  end
  initial begin
    #20000;
    err_total++;
    $display("[FAIL] %0t run timed out", $time);
    end_sim();
  end
endmodule // cpu_exec_call_clear_dec_ops_tb_top
